// >>> shared/cpc_pkg.sv
// constants, register map and state encoding of the camera parallel capture block
// assumes a 32-bit register port with byte addresses and one aligned word per register
package cpc_pkg;

  // ==========================================================================
  // register byte addresses
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_STAT   = 6'h04;
  localparam logic [5:0] OFS_RAW    = 6'h08;
  localparam logic [5:0] OFS_IEN    = 6'h0c;
  localparam logic [5:0] OFS_MSK    = 6'h10;
  localparam logic [5:0] OFS_CLR    = 6'h14;
  localparam logic [5:0] OFS_CODE   = 6'h18;
  localparam logic [5:0] OFS_UNMASK = 6'h1c;
  localparam logic [5:0] OFS_WSTART = 6'h20;
  localparam logic [5:0] OFS_WSIZE  = 6'h24;
  localparam logic [5:0] OFS_DATA   = 6'h28;

  // ==========================================================================
  // control register fields
  localparam int capture_bit              = 0;
  localparam int single_frame_mode_bit    = 1;
  localparam int crop_bit                 = 2;
  localparam int compressed_bit           = 3;
  localparam int code_sync_mode_bit       = 4;
  localparam int sample_on_rising_edge_bit = 5;
  localparam int line_sync_active_high_bit = 6;
  localparam int frame_sync_active_high_bit = 7;
  localparam int rate_lsb                 = 8;
  localparam int width_lsb                = 10;
  localparam int enable_bit               = 14;

  localparam logic [1:0] rate_all_frames     = 2'h0;
  localparam logic [1:0] rate_half_frames    = 2'h1;
  localparam logic [1:0] rate_quarter_frames = 2'h2;
  localparam logic [1:0] width_eight_bits    = 2'h0;
  localparam logic [1:0] width_ten_bits      = 2'h1;

  // ==========================================================================
  // event flags and live status bits
  localparam int num_evt          = 5;
  localparam int frame_done_irq   = 0;
  localparam int overrun_irq      = 1;
  localparam int sync_error_irq   = 2;
  localparam int frame_sync_irq   = 3;
  localparam int line_done_irq    = 4;
  localparam int line_sync_stat   = 0;
  localparam int frame_sync_stat  = 1;
  localparam int fifo_nonempty_flag = 2;

  // ==========================================================================
  // crop window fields, code bytes, reset values
  localparam int crop_x_lsb = 0;
  localparam int crop_y_lsb = 16;
  localparam int crop_x_w   = 14;
  localparam int crop_y_w   = 13;
  localparam int code_fs    = 0;
  localparam int code_ls    = 1;
  localparam int code_le    = 2;
  localparam int code_fe    = 3;
  localparam logic [7:0]  preamble_ones  = 8'hff;
  localparam logic [7:0]  preamble_zeros = 8'h00;
  localparam logic [31:0] ctrl_rst       = 32'h0000_0000;
  localparam logic [31:0] code_rst       = 32'h0000_0000;
  localparam logic [31:0] unmask_rst     = 32'hffff_ffff;
  localparam logic [31:0] window_rst     = 32'h0000_0000;
  localparam logic [4:0]  ien_rst        = 5'h00;
  localparam int          pix_w_max      = 14;

  typedef enum logic [1:0] {
    CPC_IDLE = 2'b00,
    CPC_WAIT = 2'b01,
    CPC_ACT  = 2'b10,
    CPC_DONE = 2'b11
  } cpc_state_e;

endpackage

// >>> rtl/cpc_sync.sv
// two-flop synchroniser for a bundle of asynchronous pins
// assumes the bundle is sampled far faster than it changes
`timescale 1ns/1ns
module cpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// >>> rtl/cpc_pack.sv
// packs accepted pixels into 32-bit words: four bytes, or two 16-bit halves
// assumes clear arrives at frame start; a partial word left at frame end is dropped
`timescale 1ns/1ns
module cpc_pack #(
  parameter int PIX_W = 14
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             clear,
  input  wire logic             pix_valid,
  input  wire logic             wide,
  input  wire logic [PIX_W-1:0] pix,
  output logic                  word_valid,
  output logic      [31:0]      word
);
  if (PIX_W < 8 || PIX_W > 16) begin : g_chk
    $error("cpc_pack: PIX_W must lie in 8..16");
  end

  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic [1:0]  cnt_q;
  logic [1:0]  pos;
  logic        last;

  // a pixel beside clear is the first of the new word
  assign pos  = clear ? 2'h0 : cnt_q;
  assign last = wide ? pos[0] : (pos == 2'h3);

  always_comb begin
    acc_d = acc_q;
    if (wide) begin
      acc_d[16*pos[0] +: 16] = 16'(pix);
    end else begin
      acc_d[8*pos +: 8] = pix[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_q      <= 32'h0;
      cnt_q      <= 2'h0;
      word       <= 32'h0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      if (pix_valid) begin
        acc_q <= acc_d;
        cnt_q <= last ? 2'h0 : pos + 2'h1;
        if (last) begin
          word       <= acc_d;
          word_valid <= 1'b1;
        end
      end else if (clear) begin
        cnt_q <= 2'h0;
      end
    end
  end
endmodule

// >>> rtl/cpc_top.sv
// camera parallel capture: sensor pins in, register port and transfer request out
// assumes the pixel clock is at most a quarter of CLOCK so its edges can be found
// Function
// - after enable and capture, wait for first frame start before requesting transfers
// - continuous mode keeps capturing frame after frame without stopping
// - snapshot mode waits for frame start, captures one frame, then stops
// - rate setting keeps every frame, every second, or one in four
// - width setting samples 8, 10, 12 or 14 data bits per edge in pin sync mode; code sync mode keeps only the low 8
// - line sync polarity selects active low or active high
// - frame sync polarity selects active low or active high
// - edge setting samples data on falling or rising pixel clock edge
// - pin sync mode takes frame and line bounds from sync pins
// - code sync mode finds frame and line bounds from codes in data
// - four programmable codes mark frame start, line start, line end, frame end
// - compressed mode switchable; crop and code sync unusable in it
// - crop: start line to 0x1fff; offset, line count, pixel count to 0x3fff
// - five enableable event sources: frame, overflow, sync error, frame sync, line
// - each event has a raw flag and a masked flag gated by its enable
// - live status shows line sync, frame sync and data buffer not empty
// - one write clears any combination of the five raw flags
// - captured data is read through a 32-bit data register
// - separate enable and capture controls; capture needs both
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
module cpc_top #(
  parameter int PIX_W = cpc_pkg::pix_w_max
) (
  input  wire logic             CLOCK,
  input  wire logic             RESETN,
  input  wire logic [5:0]       ADDR,
  input  wire logic [31:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [31:0]      RDATA,
  input  wire logic             PIXCLK,
  input  wire logic             HSYNC,
  input  wire logic             VSYNC,
  input  wire logic [PIX_W-1:0] PIXDATA,
  output logic                  DMA_REQ
);
  import cpc_pkg::*;

  if (PIX_W != pix_w_max) begin : g_chk
    $error("cpc_top: PIX_W must be 14");
  end

  // ==========================================================================
  // helpers
  function automatic logic [PIX_W-1:0] width_mask(logic [1:0] w);
    return PIX_W'((32'h1 << (8 + 2 * int'(w))) - 32'h1);
  endfunction

  function automatic logic code_match(logic [7:0] b, logic [7:0] c, logic [7:0] m);
    return ((b ^ c) & m) == 8'h00;
  endfunction

  function automatic logic in_range(logic [13:0] v, logic [13:0] s, logic [13:0] n);
    logic [14:0] e;
    e = {1'b0, s} + {1'b0, n};
    return (v >= s) && ({1'b0, v} < e);
  endfunction

  // ==========================================================================
  // register state
  logic [31:0]        ctrl_q;
  logic [31:0]        code_q;
  logic [31:0]        unmask_q;
  logic [31:0]        wstart_q;
  logic [31:0]        wsize_q;
  logic [31:0]        rdata_q;
  logic [31:0]        word_q;
  logic               word_full_q;
  logic [num_evt-1:0] raw_q;
  logic [num_evt-1:0] ien_q;
  logic [num_evt-1:0] ev;
  logic [num_evt-1:0] clr;
  cpc_state_e         state_q;

  logic       enable, capture, run, snap, crop_on, comp_on, code_on, rise_sel;
  logic [1:0] rate, width;
  logic       rd_data;

  assign enable   = ctrl_q[enable_bit];
  assign capture  = ctrl_q[capture_bit];
  assign run      = enable & capture;
  assign snap     = ctrl_q[single_frame_mode_bit];
  assign comp_on  = ctrl_q[compressed_bit];
  assign crop_on  = ctrl_q[crop_bit] & ~comp_on;
  assign code_on  = ctrl_q[code_sync_mode_bit] & ~comp_on;
  assign rise_sel = ctrl_q[sample_on_rising_edge_bit];
  assign rate     = ctrl_q[rate_lsb +: 2];
  assign width    = ctrl_q[width_lsb +: 2];
  assign rd_data  = RD && (ADDR == OFS_DATA);

  // ==========================================================================
  // pin sampling
  logic [PIX_W+2:0] pin_s;
  logic             pclk_s, hs_s, vs_s, pclk_d_q, pix_edge, hs_act, vs_act;
  logic             hs_prev_q, vs_prev_q;
  logic [PIX_W-1:0] pix;

  cpc_sync #(
    .W (PIX_W + 3)
  ) u_sync (
    .clk  (CLOCK),
    .rstn (RESETN),
    .d    ({PIXCLK, HSYNC, VSYNC, PIXDATA}),
    .q    (pin_s)
  );

  assign pclk_s   = pin_s[PIX_W+2];
  assign hs_s     = pin_s[PIX_W+1];
  assign vs_s     = pin_s[PIX_W];
  assign pix_edge = rise_sel ? (pclk_s & ~pclk_d_q) : (~pclk_s & pclk_d_q);
  assign hs_act   = ctrl_q[line_sync_active_high_bit] ? hs_s : ~hs_s;
  assign vs_act   = ctrl_q[frame_sync_active_high_bit] ? vs_s : ~vs_s;
  assign pix      = pin_s[PIX_W-1:0] & width_mask(width);

  // sync levels are latched on the active pixel edge so boundaries line up with data
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pclk_d_q  <= 1'b0;
      hs_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
    end else begin
      pclk_d_q <= pclk_s;
      if (pix_edge) begin
        hs_prev_q <= hs_act;
        vs_prev_q <= vs_act;
      end
    end
  end

  // ==========================================================================
  // embedded code detection
  // pixels wait three edges so a preamble can be withdrawn once its code shows up
  logic [7:0] h1_q, h2_q, h3_q;
  logic [2:0] hv_q;
  logic       in_frame_q, in_line_q, is_code, code_ev;
  logic       c_fs, c_ls, c_le, c_fe, c_bad;

  assign is_code = (hv_q == 3'b111) && (h3_q == preamble_ones)
                   && (h2_q == preamble_zeros) && (h1_q == preamble_zeros);
  assign code_ev = code_on & pix_edge & is_code;
  assign c_fs  = code_ev & code_match(pix[7:0], code_q[8*code_fs +: 8],
                                      unmask_q[8*code_fs +: 8]);
  assign c_ls  = code_ev & code_match(pix[7:0], code_q[8*code_ls +: 8],
                                      unmask_q[8*code_ls +: 8]);
  assign c_le  = code_ev & code_match(pix[7:0], code_q[8*code_le +: 8],
                                      unmask_q[8*code_le +: 8]);
  assign c_fe  = code_ev & code_match(pix[7:0], code_q[8*code_fe +: 8],
                                      unmask_q[8*code_fe +: 8]);
  assign c_bad = code_ev & ~(c_fs | c_ls | c_le | c_fe);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      h1_q       <= 8'h00;
      h2_q       <= 8'h00;
      h3_q       <= 8'h00;
      hv_q       <= 3'h0;
      in_frame_q <= 1'b0;
      in_line_q  <= 1'b0;
    end else if (!code_on) begin
      hv_q       <= 3'h0;
      in_frame_q <= 1'b0;
      in_line_q  <= 1'b0;
    end else if (pix_edge) begin
      h1_q <= pix[7:0];
      h2_q <= h1_q;
      h3_q <= h2_q;
      hv_q <= is_code ? 3'h0 : {hv_q[1:0], 1'b1};
      if (c_fs) begin
        in_frame_q <= 1'b1;
      end else if (c_fe) begin
        in_frame_q <= 1'b0;
      end
      if (c_ls && (in_frame_q || c_fs)) begin
        in_line_q <= 1'b1;
      end else if (c_le || c_fe) begin
        in_line_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // frame and line events from either source
  logic             sof, eof, eol, pix_ok;
  logic [PIX_W-1:0] pix_val;

  always_comb begin
    if (code_on) begin
      sof     = c_fs;
      eof     = c_fe;
      eol     = c_le;
      pix_ok  = pix_edge & ~is_code & hv_q[2] & in_line_q;
      pix_val = PIX_W'(h3_q);
    end else begin
      sof     = pix_edge & vs_prev_q & ~vs_act;
      eof     = pix_edge & ~vs_prev_q & vs_act;
      eol     = pix_edge & ~vs_act & ~hs_prev_q & hs_act;
      pix_ok  = pix_edge & ~vs_act & ~hs_act;
      pix_val = pix;
    end
  end

  // ==========================================================================
  // crop window
  logic [13:0] line_q, col_q;
  logic        in_win;

  // the window is read live, so it must be settled before capture starts
  assign in_win = ~crop_on
                  | (in_range(line_q, 14'(wstart_q[crop_y_lsb +: crop_y_w]),
                              wsize_q[crop_y_lsb +: crop_x_w])
                     & in_range(col_q, wstart_q[crop_x_lsb +: crop_x_w],
                                wsize_q[crop_x_lsb +: crop_x_w]));

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      line_q <= 14'h0;
      col_q  <= 14'h0;
    end else if (sof) begin
      line_q <= 14'h0;
      col_q  <= pix_ok ? 14'h1 : 14'h0;
    end else if (eol) begin
      line_q <= line_q + 14'h1;
      col_q  <= 14'h0;
    end else if (pix_ok) begin
      col_q <= col_q + 14'h1;
    end
  end

  // ==========================================================================
  // capture sequencing
  logic [1:0] frm_q;
  logic       accept;

  assign accept = (rate == rate_all_frames)
                  || ((rate == rate_half_frames) && !frm_q[0])
                  || ((rate == rate_quarter_frames) && (frm_q == 2'h0));

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      frm_q <= 2'h0;
    end else if (state_q == CPC_IDLE) begin
      frm_q <= 2'h0;
    end else if (sof) begin
      frm_q <= frm_q + 2'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= CPC_IDLE;
    end else if (!run) begin
      state_q <= CPC_IDLE;
    end else begin
      case (state_q)
        CPC_IDLE: state_q <= CPC_WAIT;
        CPC_WAIT: if (sof && accept) state_q <= CPC_ACT;
        CPC_ACT:  if (eof) state_q <= snap ? CPC_DONE : CPC_WAIT;
        CPC_DONE: state_q <= CPC_DONE;
        default:  state_q <= CPC_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // packing and the single-word data buffer
  logic        pk_valid;
  logic        pk_take;
  logic [31:0] pk_word;

  // the pixel on the frame start edge belongs to the new frame
  assign pk_take = pix_ok && in_win && run
                   && ((state_q == CPC_ACT)
                       || ((state_q == CPC_WAIT) && sof && accept));

  cpc_pack #(
    .PIX_W (PIX_W)
  ) u_pack (
    .clk        (CLOCK),
    .rstn       (RESETN),
    .clear      (sof),
    .pix_valid  (pk_take),
    .wide       (width != width_eight_bits),
    .pix        (pix_val),
    .word_valid (pk_valid),
    .word       (pk_word)
  );

  // a read in the same cycle frees the slot, so the new word is still kept
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      word_q      <= 32'h0;
      word_full_q <= 1'b0;
    end else if (pk_valid && (!word_full_q || rd_data)) begin
      word_q      <= pk_word;
      word_full_q <= 1'b1;
    end else if (rd_data) begin
      word_full_q <= 1'b0;
    end
  end

  assign DMA_REQ = word_full_q;

  // ==========================================================================
  // event flags: set beats clear in the same cycle
  assign ev[frame_done_irq] = (state_q == CPC_ACT) & eof & run;
  assign ev[overrun_irq]    = pk_valid & word_full_q & ~rd_data;
  assign ev[sync_error_irq] = c_bad & enable;
  assign ev[frame_sync_irq] = eof & enable;
  assign ev[line_done_irq]  = eol & enable;
  assign clr = (WR && (ADDR == OFS_CLR)) ? WDATA[num_evt-1:0] : '0;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      raw_q <= '0;
    end else begin
      raw_q <= (raw_q & ~clr) | ev;
    end
  end

  // ==========================================================================
  // register writes
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q   <= ctrl_rst;
      ien_q    <= ien_rst;
      code_q   <= code_rst;
      unmask_q <= unmask_rst;
      wstart_q <= window_rst;
      wsize_q  <= window_rst;
    end else if (WR) begin
      case (ADDR)
        OFS_CTRL:   ctrl_q <= WDATA;
        OFS_IEN:    ien_q <= WDATA[num_evt-1:0];
        OFS_CODE:   code_q <= WDATA;
        OFS_UNMASK: unmask_q <= WDATA;
        OFS_WSTART: wstart_q <= WDATA;
        OFS_WSIZE:  wsize_q <= WDATA;
        default:    ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ==========================================================================
  // register reads, answered one cycle later; unmapped reads return zero
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 32'h0;
    end else if (RD) begin
      case (ADDR)
        OFS_CTRL:   rdata_q <= ctrl_q;
        OFS_STAT:   rdata_q <= 32'({word_full_q, vs_act, hs_act});
        OFS_RAW:    rdata_q <= 32'(raw_q);
        OFS_IEN:    rdata_q <= 32'(ien_q);
        OFS_MSK:    rdata_q <= 32'(raw_q & ien_q);
        OFS_CODE:   rdata_q <= code_q;
        OFS_UNMASK: rdata_q <= unmask_q;
        OFS_WSTART: rdata_q <= wstart_q;
        OFS_WSIZE:  rdata_q <= wsize_q;
        OFS_DATA:   rdata_q <= word_q;
        default:    rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign RDATA = rdata_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  a_word_only_active: assert property (
    pk_valid |-> $past(state_q) == CPC_ACT) else $error("word packed outside a frame");
  a_sof_starts: assert property (
    (state_q == CPC_WAIT && sof && accept && run) |=> state_q == CPC_ACT)
    else $error("frame start not taken");
  a_cont_rearm: assert property (
    (state_q == CPC_ACT && eof && !snap && run) |=> state_q == CPC_WAIT)
    else $error("continuous capture did not rearm");
  a_snap_stops: assert property (
    (state_q == CPC_DONE && $past(state_q) == CPC_DONE) |-> !pk_valid)
    else $error("snapshot kept capturing");
  a_rate_skip: assert property (
    (state_q == CPC_WAIT && sof && rate == rate_half_frames && frm_q[0])
    |=> state_q != CPC_ACT) else $error("skipped frame captured");
  a_clear_flag: assert property (
    (WR && ADDR == OFS_CLR && WDATA[frame_done_irq] && !ev[frame_done_irq])
    |=> !raw_q[frame_done_irq]) else $error("flag not cleared");
  a_overflow_set: assert property (
    (pk_valid && word_full_q && !rd_data) |=> raw_q[overrun_irq] && $stable(word_q))
    else $error("overflow not flagged or word overwritten");
  a_masked_read: assert property (
    (RD && ADDR == OFS_MSK) |=> RDATA[num_evt-1:0] == $past(raw_q & ien_q))
    else $error("masked flags wrong");
  a_status_read: assert property (
    (RD && ADDR == OFS_STAT) |=> RDATA[fifo_nonempty_flag] == $past(word_full_q))
    else $error("buffer status wrong");
  a_data_read: assert property (
    rd_data |=> RDATA == $past(word_q) ##1 ($past(RD) || RDATA == 32'h0))
    else $error("data read wrong");
endmodule

// >>> verif/cpc_sensor.sv
// sensor model: pixel clock, line and frame sync, pixel data
// assumes frames are spaced by the caller; the pixel clock stands still between them
`timescale 1ns/1ns
module cpc_sensor (
  input  wire logic        pol,
  input  wire logic        rise,
  output logic             pixclk,
  output logic             hsync,
  output logic             vsync,
  output logic [13:0]      pixdata
);
  // ==========================================================
  // link timing
  initial begin
    pixclk = 1'b0;
    hsync = 1'b1;
    vsync = 1'b1;
    pixdata = 14'h0;
  end
  // data moves on the inactive edge, so the sampling edge sees it settled
  task automatic tick(input logic h, input logic v, input logic [13:0] d);
    pixdata = d;
    hsync = h ~^ pol;
    vsync = v ~^ pol;
    pixclk = ~rise;
    #80;
    pixclk = rise;
    #80;
  endtask
  // preamble of one ones byte and two zero bytes, then the code
  task automatic mark(input logic [7:0] c);
    tick(1'b1, 1'b1, 14'h00ff);
    repeat (2) tick(1'b1, 1'b1, 14'h0000);
    tick(1'b1, 1'b1, {6'h0, c});
  endtask
  // two lines of eight pixels framed by embedded codes; sync pins stay idle
  task automatic code_frame(input logic [31:0] codes, input logic [13:0] base);
    logic [13:0] k;
    k = base;
    #3;
    mark(codes[7:0]);
    for (int l = 0; l < 2; l++) begin
      mark(codes[15:8]);
      repeat (8) begin
        tick(1'b1, 1'b1, k);
        k = k + 14'h1;
      end
      mark(codes[23:16]);
    end
    mark(codes[31:24]);
  endtask
  task automatic frame(input int lines, input int ppl, input logic [13:0] base);
    logic [13:0] k;
    k = base;
    #3;
    repeat (2) tick(1'b1, 1'b1, ~k);
    for (int l = 0; l < lines; l++) begin
      for (int p = 0; p < ppl; p++) begin
        tick(1'b0, 1'b0, k);
        k = k + 14'h1;
      end
      repeat (2) tick(1'b1, 1'b0, ~k);
    end
    repeat (2) tick(1'b1, 1'b1, k ^ 14'h2aaa);
    // released lines must not keep showing the last pixel
    pixdata = ~pixdata;
  endtask
endmodule

// >>> verif/test_cpc_top.sv
// self-checking bench: register port master, drain of the data word, sensor model
// assumes the design's ctrl layout and the 8 pixel wide, 2 line test frames
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module test_cpc_top;
  import cpc_pkg::*;
  // ==========================================================
  // harness
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, pol = 1'b1, drain_en = 1'b0;
  logic [5:0]  addr = 6'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        pixclk, hsync, vsync, dma_req;
  logic        drd = 1'b0, rise = 1'b0;
  logic [13:0] pixdata;
  logic [1:0]  ph = 2'd0;
  logic [31:0] got[$], expq[$];
  int          err_count = 0, checks = 0, cyc = 0, seed = 32'h273df3f2;
  localparam logic [31:0] CFG = 32'h0000_40c1;
  localparam logic [31:0] CODES = 32'h9db6_80ab;
  always #5 clk = ~clk;
  cpc_top u_cpc_top (.CLOCK(clk), .RESETN(rstn), .ADDR(drd ? OFS_DATA : addr), .WDATA(wdata),
    .WR(wr), .RD(rd | drd), .RDATA(rdata), .PIXCLK(pixclk), .HSYNC(hsync), .VSYNC(vsync),
    .PIXDATA(pixdata), .DMA_REQ(dma_req));
  cpc_sensor u_cpc_sensor (.pol(pol), .rise(rise), .pixclk(pixclk), .hsync(hsync),
    .vsync(vsync), .pixdata(pixdata));
  // drain acts like the transfer channel; a started read always completes
  always @(posedge clk) begin
    if (ph == 2'd1) begin
      drd <= 1'b0;
      ph  <= 2'd2;
    end else if (ph == 2'd2) begin
      got.push_back(rdata);
      ph <= 2'd0;
    end else if (drain_en && dma_req === 1'b1) begin
      drd <= 1'b1;
      ph  <= 2'd1;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // tasks and expectations
  task automatic wreg(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [5:0] a, output logic [31:0] v);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    @(posedge clk) v = rdata;
  endtask
  function automatic logic [31:0] exp_word(input logic [13:0] b, input int j, input bit w);
    logic [13:0] p;
    p = b + 14'(w ? 2 * j : 4 * j);
    if (w) return {2'b0, p + 14'h1, 2'b0, p};
    return {p[7:0] + 8'h3, p[7:0] + 8'h2, p[7:0] + 8'h1, p[7:0]};
  endfunction
  // keeps frame f when f is a multiple of step and fewer than maxn are kept
  task automatic cap(input logic [31:0] cfg, input int nf, input int step, input int maxn,
                     input bit w);
    logic [13:0] b;
    rise = cfg[sample_on_rising_edge_bit];
    wreg(OFS_CTRL, 32'h0);
    wreg(OFS_CTRL, cfg);
    got.delete();
    expq.delete();
    drain_en = 1'b1;
    for (int f = 0; f < nf; f++) begin
      b = 14'($random(seed));
      if (cfg[code_sync_mode_bit])
        u_cpc_sensor.code_frame(CODES, b);
      else
        u_cpc_sensor.frame(2, 8, b);
      // the crop scenario keeps pixels 4..7 of line 1 only: the fourth word
      if (f % step == 0 && f / step < maxn)
        for (int j = 0; j < (w ? 8 : 4); j++)
          if (!cfg[crop_bit] || j == 3) expq.push_back(exp_word(b, j, w));
    end
    repeat (30) @(posedge clk);
    drain_en = 1'b0;
    repeat (3) @(posedge clk);
    `CHK("word count", expq.size(), got.size())
    for (int i = 0; i < expq.size() && i < got.size(); i++)
      `CHK("data word", expq[i], got[i])
    $display("test done cfg %h", cfg);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rreg(OFS_CTRL, d);
    `CHK("ctrl reset", ctrl_rst, d)
    rreg(OFS_UNMASK, d);
    `CHK("code mask reset", unmask_rst, d)
    rreg(6'h2c, d);
    `CHK("unmapped read", 32'h0, d)
    wreg(OFS_IEN, 32'h9);
    cap(CFG, 2, 1, 2, 1'b0);
    rreg(OFS_RAW, d);
    `CHK("raw flags", 32'h19, d)
    rreg(OFS_MSK, d);
    `CHK("masked flags", 32'h9, d)
    cap(CFG | 32'h2, 2, 1, 1, 1'b0);
    cap(CFG | 32'h100, 4, 2, 2, 1'b0);
    cap(CFG | 32'h200, 4, 4, 1, 1'b0);
    cap(CFG | 32'hc00, 1, 1, 1, 1'b1);
    cap(CFG | 32'h20, 1, 1, 1, 1'b0);
    wreg(OFS_CTRL, 32'h0);
    wreg(OFS_WSTART, 32'h0001_0004);
    wreg(OFS_WSIZE, 32'h0001_0004);
    cap(CFG | 32'h4, 1, 1, 1, 1'b0);
    wreg(OFS_CODE, CODES);
    cap(CFG | 32'h10, 1, 1, 1, 1'b0);
    pol = 1'b0;
    cap(CFG & ~32'hc0, 1, 1, 1, 1'b0);
    pol = 1'b1;
    wreg(OFS_CTRL, CFG);
    u_cpc_sensor.frame(2, 8, 14'h0123);
    rreg(OFS_STAT, d);
    `CHK("buffer full", 1'b1, d[fifo_nonempty_flag])
    rreg(OFS_RAW, d);
    `CHK("overflow flag", 1'b1, d[overrun_irq])
    rreg(OFS_DATA, d);
    `CHK("kept word", exp_word(14'h0123, 0, 1'b0), d)
    wreg(OFS_CLR, 32'h1f);
    rreg(OFS_RAW, d);
    `CHK("cleared flags", 32'h0, d)
    $display("test done overflow");
    tally_and_finish();
  end
endmodule
